// ==== core/pmcs_pkg.sv ====
// Functional notes
// - Level mode: pin high with supply above threshold turns on, sets flag.
// - Edge mode: falling pin with supply above threshold turns on, sets flag.
// - A turn-on event moves the device from off or sleep into on.
// - Regulators enabled in sleep stay enabled when going back to on.
// - Edge mode raises the power-on flag on both edges, each debounced.
// - Debounce select picks turn-on and falling debounce times; rising always uses the short time.
// - Power-on flag holds until software clears it or the device goes off.
// - Power-on sense bit follows the request pin directly, undebounced.
// - Standby follows the standby input, polarity set by the invert bit.
// - Default mode releases host reset 2 ms after last slot, asserts on off.
// - Fault mode releases host reset after start-up only if fault-free.
// - Fault mode: 1.8 ms fault asserts host reset, over 100 ms turns off.
// - Power-good mode fuse bit set to 1 selects fault-supervised reset.
// - Unmasked fault asserts interrupt output; writing 1 clears the flag.
// - Card rail select high picks low range, low picks high range.
// - Without I/O supply the card rail select reads high.
// - Power-up copies fuses into shadow registers, skipped in trial mode.
// - Shadow voltage and slot codes copied to live at power-up; later shadow writes to them do not reach live.
// - Slot code n enables a regulator n slot delays after turn-on; zero off.
// - Zero-code regulators are enabled only by host write after start-up.
// - Slot delay select gives 500 us at 0 and 2000 us at 1.
// - The sequence ends at the highest slot any regulator uses.
package pmcs_pkg;

  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 50;
  localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int CNT_W = 17;
  localparam int TMR_W = 6;
  localparam int ADDR_W = 12;
  localparam int REG_COUNT = 8;
  localparam int CODE_W = 4;
  localparam int CFG_W = 6;

  // Times in microseconds
  localparam int DBNC_ZERO_US = 0;
  localparam int DBNC_SHORT_US = 31250;
  localparam int DBNC_MID_US = 125000;
  localparam int DBNC_LONG_US = 750000;
  localparam int OFF_HOLD_US = 4000000;
  localparam int SLOT_FAST_US = 500;
  localparam int SLOT_SLOW_US = 2000;
  localparam int RST_DELAY_US = 2000;
  localparam int FAULT_RST_US = 1800;
  localparam int FAULT_OFF_US = 100000;

  // Times in slow ticks, least times rounded up
  localparam logic [CNT_W-1:0] TK_ZERO =
    CNT_W'((DBNC_ZERO_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_SHORT =
    CNT_W'((DBNC_SHORT_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_MID =
    CNT_W'((DBNC_MID_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_LONG =
    CNT_W'((DBNC_LONG_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_OFF_HOLD =
    CNT_W'((OFF_HOLD_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_FAULT_RST =
    CNT_W'((FAULT_RST_US + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] TK_FAULT_OFF = CNT_W'(FAULT_OFF_US / TICK_US);
  localparam logic [TMR_W-1:0] TK_SLOT_FAST =
    TMR_W'((SLOT_FAST_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_SLOT_SLOW =
    TMR_W'((SLOT_SLOW_US + TICK_US - 1) / TICK_US);
  localparam logic [TMR_W-1:0] TK_RST_DELAY =
    TMR_W'((RST_DELAY_US + TICK_US - 1) / TICK_US);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SLOTS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_V1A_SHADOW = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_V1A_LIVE = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_REG_EN = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h018;

  // Status fields
  localparam int ST_ON_IRQ = 0;
  localparam int ST_FAULT_IRQ = 1;
  localparam int ST_SENSE = 2;
  localparam int ST_STBY = 3;
  localparam int ST_CARD_LOW = 4;
  localparam int ST_HOST_RST = 5;
  localparam int ST_STATE = 8;

  // Control fields
  localparam int CT_FAULT_MASK = 0;
  localparam int CT_TRIAL = 1;
  localparam int CT_SLEEP_OFF = 2;
  localparam int CT_KEEP = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hff07;

  // Regulators with 4-bit slot codes; the rest use 3 bits
  localparam logic [REG_COUNT-1:0] LDO_MASK = 8'hc0;
  localparam logic [7:0] VOLT_LIVE_RST = 8'h00;

  typedef struct packed {
    logic [7:0] buck1a_volt;
    logic [31:0] slot_codes;
    logic pg_mode;
    logic slot_delay;
    logic stby_inv;
    logic [1:0] dbnc;
    logic edge_sel;
  } pmcs_fuse_s;

  localparam pmcs_fuse_s FUSE_RST = '0;

  typedef enum logic [2:0] {
    PS_OFF, PS_LOAD, PS_SEQ, PS_RSTWAIT, PS_ON, PS_SLEEP
  } pmcs_state_e;

endpackage : pmcs_pkg

// ==== core/pmcs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int NUM_REG = REG_COUNT
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Control pins
  input wire logic POWER_ON_REQUEST,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic STANDBY,
  input wire logic CARD_RAIL_SELECT,
  input wire logic IO_SUPPLY_OK,
  input wire logic FAULT,
  input wire pmcs_fuse_s FUSE,
  // Open-drain outputs
  output logic HOST_RESET_OUT_O,
  output logic HOST_RESET_OUT_OE,
  output logic IRQ_OUT_N_O,
  output logic IRQ_OUT_N_OE,
  // Regulator control
  output logic [NUM_REG-1:0] REG_ENABLE,
  output logic [7:0] BUCK1A_VOLTAGE,
  output logic CARD_RANGE_LOW,
  output logic STANDBY_ACTIVE
);

  localparam int TDIV_W = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1 || NUM_REG < 1 || NUM_REG > REG_COUNT)
  begin : g_bad_param
    $error("pmcs_top: unsupported parameter values");
  end

  pmcs_state_e state;
  pmcs_state_e next_state;
  pmcs_fuse_s shadow;
  pmcs_fuse_s load_src;
  logic [TDIV_W-1:0] tick_cnt;
  logic tick;
  logic cold;
  logic pin_q;
  logic pin_chg;
  logic [CNT_W-1:0] stab_cnt;
  logic [CNT_W-1:0] fault_cnt;
  logic [CNT_W-1:0] thr_on;
  logic [CNT_W-1:0] thr_fall;
  logic on_done;
  logic irq_done;
  logic on_irq;
  logic fault_irq;
  logic fault_q;
  logic fault_seen;
  logic host_rst;
  logic [15:0] ctrl;
  logic [31:0] seq_codes;
  logic [7:0] volt_live;
  logic [NUM_REG-1:0] reg_en;
  logic [NUM_REG-1:0] slot_hit;
  logic [NUM_REG-1:0] zero_mask;
  logic [CODE_W-1:0] code [NUM_REG];
  logic [CODE_W-1:0] max_slot;
  logic [CODE_W-1:0] slot_idx;
  logic [CODE_W-1:0] next_slot;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] slot_len;
  logic stby;
  logic card_low;
  logic [31:0] rd_mux;
  logic [31:0] prdata;

  // Bus decode
  logic setup;
  logic access;
  logic wr;
  logic sel_cfg;
  logic sel_slots;
  logic sel_v1a_sh;
  logic sel_v1a_live;
  logic sel_reg_en;
  logic sel_status;
  logic sel_ctrl;
  logic addr_hit;
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;
  assign sel_cfg = PADDR == OFF_CONFIG;
  assign sel_slots = PADDR == OFF_SLOTS;
  assign sel_v1a_sh = PADDR == OFF_V1A_SHADOW;
  assign sel_v1a_live = PADDR == OFF_V1A_LIVE;
  assign sel_reg_en = PADDR == OFF_REG_EN;
  assign sel_status = PADDR == OFF_STATUS;
  assign sel_ctrl = PADDR == OFF_CTRL;
  assign addr_hit = sel_cfg || sel_slots || sel_v1a_sh || sel_v1a_live ||
                    sel_reg_en || sel_status || sel_ctrl;

  // Event decode
  logic trial;
  logic pg_mode;
  logic idle;
  logic active;
  logic on_level;
  logic turn_on_evt;
  logic fall_evt;
  logic rise_evt;
  logic on_set;
  logic off_evt;
  logic fault_off;
  logic fault_rst;
  logic seq_end;
  logic slot_step;
  logic rst_wait_done;
  logic turn_off;
  assign trial = ctrl[CT_TRIAL];
  assign pg_mode = shadow.pg_mode;
  assign load_src = trial ? shadow : FUSE;
  assign idle = state == PS_OFF || state == PS_SLEEP;
  assign active = state == PS_SEQ || state == PS_RSTWAIT || state == PS_ON;
  assign pin_chg = POWER_ON_REQUEST != pin_q;
  assign on_level = shadow.edge_sel ? !pin_q : pin_q;
  assign turn_on_evt = idle && MAIN_SUPPLY_OK && on_level && !on_done &&
                       stab_cnt >= thr_on;
  assign fall_evt = shadow.edge_sel && !pin_q && !irq_done &&
                    stab_cnt >= thr_fall;
  assign rise_evt = shadow.edge_sel && pin_q && !irq_done &&
                    stab_cnt >= TK_SHORT;
  assign on_set = turn_on_evt || fall_evt || rise_evt;
  assign off_evt = active && !pin_q &&
                   (!shadow.edge_sel || stab_cnt >= TK_OFF_HOLD);
  assign fault_rst = pg_mode && active && fault_cnt >= TK_FAULT_RST;
  assign fault_off = pg_mode && active && fault_cnt > TK_FAULT_OFF;
  assign slot_len = shadow.slot_delay ? TK_SLOT_SLOW : TK_SLOT_FAST;
  assign next_slot = slot_idx + 4'h1;
  assign seq_end = state == PS_SEQ && slot_idx == max_slot;
  assign slot_step = state == PS_SEQ && !seq_end && tick &&
                     tmr == slot_len - 6'h01;
  assign rst_wait_done = state == PS_RSTWAIT && tick &&
                         tmr == TK_RST_DELAY - 6'h01;
  assign turn_off = active &&
                    (next_state == PS_OFF || next_state == PS_SLEEP);

  // Debounce times per select code
  always_comb
  begin
    thr_on = TK_SHORT;
    thr_fall = TK_SHORT;
    case (shadow.dbnc)
      2'b00: thr_on = TK_ZERO;
      2'b01: thr_on = TK_SHORT;
      2'b10:
      begin
        thr_on = TK_MID;
        thr_fall = TK_MID;
      end
      default:
      begin
        thr_on = TK_LONG;
        thr_fall = TK_LONG;
      end
    endcase
  end

  // Per-regulator slot codes
  for (genvar i = 0; i < NUM_REG; i++)
  begin : g_reg
    assign code[i] = LDO_MASK[i] ? seq_codes[i*CODE_W +: CODE_W] :
                     {1'b0, seq_codes[i*CODE_W +: CODE_W-1]};
    assign slot_hit[i] = code[i] == next_slot;
    assign zero_mask[i] = code[i] == '0;
  end

  always_comb
  begin
    max_slot = '0;
    for (int i = 0; i < NUM_REG; i++)
    begin
      if (code[i] > max_slot)
      begin
        max_slot = code[i];
      end
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      PS_OFF:
        if (turn_on_evt)
          next_state = PS_LOAD;
      PS_SLEEP:
        if (turn_on_evt)
          next_state = PS_SEQ;
      PS_LOAD:
        next_state = PS_SEQ;
      PS_SEQ:
        if (seq_end)
          next_state = pg_mode ? PS_ON : PS_RSTWAIT;
      PS_RSTWAIT:
        if (rst_wait_done)
          next_state = PS_ON;
      PS_ON:
        next_state = PS_ON;
      default:
        next_state = PS_OFF;
    endcase
    if (fault_off)
      next_state = PS_OFF;
    else if (off_evt)
      next_state = ctrl[CT_SLEEP_OFF] ? PS_SLEEP : PS_OFF;
  end

  always_comb
  begin
    rd_mux = '0;
    if (sel_cfg)
      rd_mux[CFG_W-1:0] = shadow[CFG_W-1:0];
    else if (sel_slots)
      rd_mux = shadow.slot_codes;
    else if (sel_v1a_sh)
      rd_mux[7:0] = shadow.buck1a_volt;
    else if (sel_v1a_live)
      rd_mux[7:0] = volt_live;
    else if (sel_reg_en)
      rd_mux[NUM_REG-1:0] = reg_en;
    else if (sel_ctrl)
      rd_mux[15:0] = ctrl;
    else if (sel_status)
    begin
      rd_mux[ST_ON_IRQ] = on_irq;
      rd_mux[ST_FAULT_IRQ] = fault_irq;
      rd_mux[ST_SENSE] = POWER_ON_REQUEST;
      rd_mux[ST_STBY] = stby;
      rd_mux[ST_CARD_LOW] = card_low;
      rd_mux[ST_HOST_RST] = host_rst;
      rd_mux[ST_STATE +: 3] = state;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tick_cnt <= '0;
      cold <= 1'b1;
      pin_q <= 1'b0;
      fault_q <= 1'b0;
      state <= PS_OFF;
      prdata <= '0;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      cold <= 1'b0;
      pin_q <= POWER_ON_REQUEST;
      fault_q <= FAULT;
      state <= next_state;
      prdata <= setup ? rd_mux : prdata;
    end
  end
  assign tick = tick_cnt == TDIV_W'(TICK_CYCLES - 1);

  // Stability and fault persistence counters
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stab_cnt <= '0;
      fault_cnt <= '0;
    end
    else
    begin
      if (pin_chg)
        stab_cnt <= '0;
      else if (tick && stab_cnt != '1)
        stab_cnt <= stab_cnt + 1'b1;
      if (!FAULT)
        fault_cnt <= '0;
      else if (tick && fault_cnt != '1)
        fault_cnt <= fault_cnt + 1'b1;
    end
  end

  // One-shot guards for each stable pin run
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      on_done <= 1'b1;
      irq_done <= 1'b1;
    end
    else
    begin
      if (pin_chg)
        on_done <= 1'b0;
      else if (cold)
        on_done <= FUSE.edge_sel;
      else if (turn_on_evt)
        on_done <= 1'b1;
      if (pin_chg)
        irq_done <= 1'b0;
      else if (fall_evt || rise_evt)
        irq_done <= 1'b1;
    end
  end

  // Flags: a new event beats a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      on_irq <= 1'b0;
      fault_irq <= 1'b0;
      fault_seen <= 1'b0;
    end
    else
    begin
      if (on_set)
        on_irq <= 1'b1;
      else if ((wr && sel_status && PWDATA[ST_ON_IRQ]) ||
               (next_state == PS_OFF && state != PS_OFF))
        on_irq <= 1'b0;
      if (FAULT && !fault_q)
        fault_irq <= 1'b1;
      else if (wr && sel_status && PWDATA[ST_FAULT_IRQ])
        fault_irq <= 1'b0;
      if (state == PS_LOAD || (state == PS_SLEEP && next_state == PS_SEQ))
        fault_seen <= 1'b0;
      else if (state == PS_SEQ && FAULT)
        fault_seen <= 1'b1;
    end
  end

  // Host reset, asserted while high
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      host_rst <= 1'b1;
    else if (turn_off)
      host_rst <= 1'b1;
    else if (fault_rst)
      host_rst <= 1'b1;
    else if (rst_wait_done)
      host_rst <= 1'b0;
    else if (seq_end && pg_mode && !fault_seen && !FAULT)
      host_rst <= 1'b0;
  end

  // Sequencer timer and slot position
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tmr <= '0;
      slot_idx <= '0;
    end
    else if (next_state != state)
    begin
      tmr <= '0;
      slot_idx <= '0;
    end
    else if (slot_step)
    begin
      tmr <= '0;
      slot_idx <= next_slot;
    end
    else if (tick)
      tmr <= tmr + 1'b1;
  end

  // Shadow configuration
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      shadow <= FUSE_RST;
    else if (cold || state == PS_LOAD)
      shadow <= load_src;
    else if (wr && sel_cfg)
      shadow[CFG_W-1:0] <= PWDATA[CFG_W-1:0];
    else if (wr && sel_slots)
      shadow.slot_codes <= PWDATA;
    else if (wr && sel_v1a_sh)
      shadow.buck1a_volt <= PWDATA[7:0];
  end

  // Live regulator state
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      seq_codes <= '0;
      volt_live <= VOLT_LIVE_RST;
      reg_en <= '0;
      ctrl <= CTRL_RST;
    end
    else
    begin
      if (state == PS_LOAD)
      begin
        seq_codes <= load_src.slot_codes;
        volt_live <= load_src.buck1a_volt;
      end
      else if (wr && sel_v1a_live)
        volt_live <= PWDATA[7:0];
      if (next_state == PS_OFF)
        reg_en <= '0;
      else if (next_state == PS_SLEEP && state != PS_SLEEP)
        reg_en <= reg_en & ctrl[CT_KEEP +: NUM_REG];
      else if (slot_step)
        reg_en <= reg_en | slot_hit;
      else if (wr && sel_reg_en && state == PS_ON)
        reg_en <= PWDATA[NUM_REG-1:0];
      if (wr && sel_ctrl)
        ctrl <= PWDATA[15:0] & CTRL_WMASK;
    end
  end

  // Standby and card rail range
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stby <= 1'b0;
      card_low <= 1'b1;
    end
    else
    begin
      stby <= STANDBY ^ shadow.stby_inv;
      card_low <= IO_SUPPLY_OK ? CARD_RAIL_SELECT : 1'b1;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = access && !addr_hit;
  assign PRDATA = prdata;
  assign HOST_RESET_OUT_O = 1'b0;
  assign HOST_RESET_OUT_OE = host_rst;
  assign IRQ_OUT_N_O = 1'b0;
  assign IRQ_OUT_N_OE = fault_irq && !ctrl[CT_FAULT_MASK];
  assign REG_ENABLE = reg_en;
  assign BUCK1A_VOLTAGE = volt_live;
  assign CARD_RANGE_LOW = card_low;
  assign STANDBY_ACTIVE = stby;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  AST_SENSE_READ: assert property (
    (setup && sel_status) |=> PRDATA[ST_SENSE] == $past(POWER_ON_REQUEST))
    else $error("sense bit does not follow pin");
  AST_TURN_ON: assert property (
    turn_on_evt |=> (state == PS_LOAD || state == PS_SEQ))
    else $error("turn-on did not leave off or sleep");
  AST_ON_IRQ_SET: assert property (
    on_set |=> on_irq)
    else $error("power-on flag not set");
  AST_ON_IRQ_OFF: assert property (
    (state != PS_OFF ##1 state == PS_OFF) |-> (!on_irq || $past(on_set)))
    else $error("power-on flag kept through off");
  AST_DBNC_MID: assert property (
    (fall_evt && shadow.dbnc == 2'b10) |-> stab_cnt >= TK_MID)
    else $error("falling debounce too short");
  AST_SLEEP_KEEP: assert property (
    (state == PS_SLEEP ##1 state == PS_SEQ) |->
      (reg_en & $past(reg_en)) == $past(reg_en))
    else $error("sleep regulator dropped on wake");
  AST_ZERO_CODE: assert property (
    (state == PS_SEQ && $past(state) == PS_SEQ) |->
      (reg_en & zero_mask & ~$past(reg_en)) == '0)
    else $error("zero-code regulator enabled by sequence");
  AST_SEQ_END: assert property (
    seq_end |=> state != PS_SEQ)
    else $error("sequence ran past last used slot");
  AST_RST_TIMER: assert property (
    (state == PS_ON && $past(state) == PS_RSTWAIT) |->
      (!host_rst && $past(tmr) == TK_RST_DELAY - 6'h01))
    else $error("host reset release timing wrong");
  AST_FAULT_RST: assert property (
    fault_rst |=> host_rst)
    else $error("persistent fault did not assert reset");
  AST_FAULT_OFF: assert property (
    fault_off |=> (state == PS_OFF && host_rst && reg_en == '0))
    else $error("long fault did not turn off");
  AST_IRQ_SET: assert property (
    (FAULT && !fault_q && !ctrl[CT_FAULT_MASK] && !(wr && sel_ctrl)) |=>
      IRQ_OUT_N_OE)
    else $error("fault interrupt not raised");
  AST_CARD: assert property (
    !IO_SUPPLY_OK |=> CARD_RANGE_LOW)
    else $error("card range not low without io supply");
  AST_STBY: assert property (
    1'b1 |=> STANDBY_ACTIVE == ($past(STANDBY) ^ $past(shadow.stby_inv)))
    else $error("standby level wrong");
  AST_LIVE_HOLD: assert property (
    (wr && sel_v1a_sh && state == PS_ON) |=>
      BUCK1A_VOLTAGE == $past(BUCK1A_VOLTAGE))
    else $error("shadow write changed live voltage");
  AST_FUSE_LOAD: assert property (
    (state == PS_LOAD && !trial) |=> shadow == $past(FUSE))
    else $error("fuses not loaded at power-up");

endmodule : pmcs_top
`default_nettype wire

// ==== dv/pmcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmcs_host
(
  // Open-drain pins from the device
  input wire logic rst_o,
  input wire logic rst_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  // Push-button
  input wire logic button,
  // Levels seen by the host
  output logic rst_n,
  output logic irq_n,
  output logic request
);
  // Pull-ups win when the device lets go
  assign rst_n = rst_oe ? rst_o : 1'b1;
  assign irq_n = irq_oe ? irq_o : 1'b1;
  assign request = button;
endmodule : pmcs_host
`default_nettype wire

// ==== dv/pmic_control_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmic_control_sequencer_test;
  import pmcs_pkg::*;
  localparam pmcs_fuse_s FZ = '{buck1a_volt: 8'h33, slot_codes: 32'h21,
    default: '0};
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, err, POWER_ON_REQUEST, rst_o, rst_oe, irq_o, irq_oe;
  logic host_rst_n, irq_n, CARD_RANGE_LOW, STANDBY_ACTIVE;
  logic button = 1'b0;
  logic STANDBY = 1'b0;
  logic CARD_RAIL_SELECT = 1'b1;
  logic IO_SUPPLY_OK = 1'b1;
  logic FAULT = 1'b0;
  logic [7:0] REG_ENABLE, BUCK1A_VOLTAGE;
  // Rows: select, io supply, standby, expected low range, expected standby
  logic [4:0] rows [4] = '{5'b11010, 5'b01101, 5'b00010, 5'b10111};
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  always #10 CLK_SYS = ~CLK_SYS;

  pmcs_top #(.TICK_CYCLES(2)) uut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POWER_ON_REQUEST(POWER_ON_REQUEST), .MAIN_SUPPLY_OK(1'b1),
    .STANDBY(STANDBY), .CARD_RAIL_SELECT(CARD_RAIL_SELECT),
    .IO_SUPPLY_OK(IO_SUPPLY_OK), .FAULT(FAULT), .FUSE(FZ),
    .HOST_RESET_OUT_O(rst_o), .HOST_RESET_OUT_OE(rst_oe),
    .IRQ_OUT_N_O(irq_o), .IRQ_OUT_N_OE(irq_oe), .REG_ENABLE(REG_ENABLE),
    .BUCK1A_VOLTAGE(BUCK1A_VOLTAGE), .CARD_RANGE_LOW(CARD_RANGE_LOW),
    .STANDBY_ACTIVE(STANDBY_ACTIVE));

  pmcs_host host (.rst_o(rst_o), .rst_oe(rst_oe), .irq_o(irq_o),
    .irq_oe(irq_oe), .button(button), .rst_n(host_rst_n), .irq_n(irq_n),
    .request(POWER_ON_REQUEST));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
  endtask : tick

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // Watchdog against a hung wait
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      close_out;
    end
  end

  initial
  begin
    tick(5);
    chk({host_rst_n, REG_ENABLE}, 0);
    RST_N <= 1'b1;
    tick(3);
    button <= 1'b1;
    while (REG_ENABLE[0] !== 1'b1) tick(1);
    chk(REG_ENABLE, 8'h01);
    n = 0;
    while (REG_ENABLE[1] !== 1'b1)
    begin
      tick(1);
      n++;
    end
    chk(n >= 17 && n <= 22, 1);
    n = 0;
    while (host_rst_n !== 1'b1)
    begin
      tick(1);
      n++;
    end
    chk(n >= 74 && n <= 84, 1);
    chk(REG_ENABLE, 8'h03);
    apb(1'b0, OFF_STATUS, 0);
    chk(rd[2:0], 3'b101);
    apb(1'b1, OFF_STATUS, 1);
    apb(1'b0, OFF_STATUS, 0);
    chk(rd[0], 0);
    apb(1'b1, OFF_V1A_SHADOW, 32'h5a);
    tick(2);
    chk(BUCK1A_VOLTAGE, 8'h33);
    apb(1'b1, OFF_V1A_LIVE, 32'ha5);
    apb(1'b1, OFF_REG_EN, 32'h83);
    tick(2);
    chk({BUCK1A_VOLTAGE, REG_ENABLE}, 16'ha583);
    apb(1'b0, 12'hffc, 0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    foreach (rows[i])
    begin
      {CARD_RAIL_SELECT, IO_SUPPLY_OK, STANDBY} <= rows[i][4:2];
      tick(4);
      chk({CARD_RANGE_LOW, STANDBY_ACTIVE}, rows[i][1:0]);
    end
    STANDBY <= 1'b0;
    FAULT <= 1'b1;
    tick(3);
    chk(irq_n, 0);
    FAULT <= 1'b0;
    apb(1'b1, OFF_STATUS, 2);
    tick(2);
    chk(irq_n, 1);
    apb(1'b1, OFF_CTRL, 1);
    FAULT <= 1'b1;
    tick(3);
    chk(irq_n, 1);
    apb(1'b1, OFF_CTRL, 0);
    tick(2);
    chk(irq_n, 0);
    FAULT <= 1'b0;
    apb(1'b1, OFF_STATUS, 2);
    button <= 1'b0;
    while (host_rst_n !== 1'b0) tick(1);
    tick(2);
    chk(REG_ENABLE, 0);
    button <= 1'b1;
    while (host_rst_n !== 1'b1) tick(1);
    chk(REG_ENABLE, 8'h03);
    // Trial mode, then edge mode by shadow write: both edges flag
    apb(1'b1, OFF_STATUS, 1);
    apb(1'b1, OFF_CTRL, 2);
    apb(1'b1, OFF_CONFIG, 1);
    button <= 1'b0;
    tick(1300);
    apb(1'b0, OFF_STATUS, 0);
    chk(rd[10:0], 11'h411);
    apb(1'b1, OFF_STATUS, 1);
    button <= 1'b1;
    tick(1300);
    apb(1'b0, OFF_STATUS, 0);
    chk(rd[10:0], 11'h415);
    chk(REG_ENABLE, 8'h03);
    close_out;
  end
endmodule : pmic_control_sequencer_test
`default_nettype wire
